/* File: design/flpoll_pkg.sv */
// constants for the flash status poll controller
package flpoll_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int T_CYC_NS = 10;
  localparam int T_RD_NS  = 70;
  localparam int T_GAP_NS = 30;
  localparam int T_WE_NS  = 40;
  localparam int RD_CYC   = (T_RD_NS + T_CYC_NS - 1) / T_CYC_NS;
  localparam int GAP_CYC  = (T_GAP_NS + T_CYC_NS - 1) / T_CYC_NS;
  localparam int WE_CYC   = (T_WE_NS + T_CYC_NS - 1) / T_CYC_NS;
  // ----------------------------------------
  // status bit positions and command
  // ----------------------------------------
  localparam int BIT_POLL = 7;
  localparam int BIT_ALT  = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_SECT = 2;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] DQ_RST    = 8'h00;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD   = 3'b001,
    S_GAP  = 3'b010,
    S_WR   = 3'b011,
    S_WGAP = 3'b100,
    S_HOLD = 3'b101
  } flpoll_st_e;
  typedef enum logic [2:0] {
    PH_A = 3'b000,
    PH_B = 3'b001,
    PH_C = 3'b010,
    PH_D = 3'b011,
    PH_E = 3'b100
  } flpoll_ph_e;
endpackage

/* File: design/flpoll_ctrl.sv */
// host side controller that polls flash write status
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - poll reads use the program address
// - erase poll reads inside a chosen sector
// - only the read after bit 7 true is data
// - toggle poll starts with two reads compared
// - toggling with fail bit: recheck, then reset
// - resumed polling restarts at the double read
// - reset command is data F0 anywhere
module flpoll_ctrl #(
  parameter int AW = 19
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          start,
  input  wire logic          use_data_poll,
  input  wire logic [AW-1:0] poll_addr,
  input  wire logic          expect_d7,
  input  wire logic          pause,
  output logic               busy,
  output logic               done,
  output logic               failed,
  output logic [7:0]         rd_data,
  output logic [AW-1:0]      fl_addr,
  output logic               fl_ce_n,
  output logic               fl_oe_n,
  output logic               fl_we_n,
  input  wire logic [7:0]    fl_dq_in,
  output logic [7:0]         fl_dq_out,
  output logic               fl_dq_oe_n
);
  import flpoll_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    flpoll_st_e     st;
    flpoll_ph_e     ph;
    logic [2:0]     cnt;
    logic [2:0]     rds;
    logic           dp;
    logic           exp7;
    logic           fin;
    logic           wr;
    logic           fail;
    logic [7:0]     first;
    logic           done;
    logic           failed;
    logic [7:0]     data;
    logic [AW-1:0]  addr;
    logic           ce_n;
    logic           oe_n;
    logic           we_n;
    logic [7:0]     dq;
    logic           dq_oe_n;
  } flpoll_s;

  flpoll_s q;
  flpoll_s d;

  function automatic logic [2:0] cyc3(input int n);
    cyc3 = n[2:0] - 3'd1;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.failed = 1'b0;
    unique case (q.st)
      S_IDLE:
      begin
        if (start)
        begin
          d.addr = poll_addr;
          d.dp = use_data_poll;
          d.exp7 = expect_d7;
          d.ph = PH_A;
          d.rds = 3'd0;
          d.fin = 1'b0;
          d.wr = 1'b0;
          d.fail = 1'b0;
          d.st = S_RD;
          d.ce_n = 1'b0;
          d.oe_n = 1'b0;
          d.cnt = cyc3(RD_CYC);
        end
      end
      S_RD:
      begin
        if (q.cnt != 3'd0)
          d.cnt = q.cnt - 3'd1;
        else
        begin
          d.ce_n = 1'b1;
          d.oe_n = 1'b1;
          d.st = S_GAP;
          d.cnt = cyc3(GAP_CYC);
          if (q.rds != 3'd7)
            d.rds = q.rds + 3'd1;
          if (q.ph == PH_E)
          begin
            d.fin = 1'b1;
            d.data = fl_dq_in;
          end
          else if (q.dp)
          begin
            if (fl_dq_in[BIT_POLL] == q.exp7)
              d.ph = PH_E;
            else if (q.ph == PH_C)
              d.wr = 1'b1;
            else if (fl_dq_in[BIT_FAIL])
              d.ph = PH_C;
          end
          else
          begin
            unique case (q.ph)
              PH_A, PH_C:
              begin
                d.first = fl_dq_in;
                d.ph = (q.ph == PH_A) ? PH_B : PH_D;
              end
              PH_B:
              begin
                if (fl_dq_in[BIT_ALT] == q.first[BIT_ALT])
                  d.ph = PH_E;
                else if (fl_dq_in[BIT_FAIL])
                  d.ph = PH_C;
                else
                  d.ph = PH_A;
              end
              default:
              begin
                if (fl_dq_in[BIT_ALT] == q.first[BIT_ALT])
                  d.ph = PH_E;
                else
                  d.wr = 1'b1;
              end
            endcase
          end
        end
      end
      S_GAP:
      begin
        if (q.cnt != 3'd0)
          d.cnt = q.cnt - 3'd1;
        else if (q.fin)
        begin
          d.st = S_IDLE;
          d.done = 1'b1;
        end
        else if (q.wr)
        begin
          d.st = S_WR;
          d.ce_n = 1'b0;
          d.we_n = 1'b0;
          d.dq = CMD_RESET;
          d.dq_oe_n = 1'b0;
          d.cnt = cyc3(WE_CYC);
        end
        else if (pause && q.ph != PH_E)
          d.st = S_HOLD;
        else
        begin
          d.st = S_RD;
          d.ce_n = 1'b0;
          d.oe_n = 1'b0;
          d.cnt = cyc3(RD_CYC);
        end
      end
      S_HOLD:
      begin
        if (!pause)
        begin
          d.ph = PH_A;
          d.st = S_RD;
          d.ce_n = 1'b0;
          d.oe_n = 1'b0;
          d.cnt = cyc3(RD_CYC);
        end
      end
      S_WR:
      begin
        if (q.cnt != 3'd0)
          d.cnt = q.cnt - 3'd1;
        else
        begin
          d.ce_n = 1'b1;
          d.we_n = 1'b1;
          d.dq_oe_n = 1'b1;
          d.st = S_WGAP;
          d.cnt = cyc3(GAP_CYC);
        end
      end
      default:
      begin
        if (q.cnt != 3'd0)
          d.cnt = q.cnt - 3'd1;
        else
        begin
          d.st = S_IDLE;
          d.done = 1'b1;
          d.failed = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.ph <= PH_A;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
      q.dq <= DQ_RST;
      q.dq_oe_n <= 1'b1;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy       = (q.st != S_IDLE);
  assign done       = q.done;
  assign failed     = q.failed;
  assign rd_data    = q.data;
  assign fl_addr    = q.addr;
  assign fl_ce_n    = q.ce_n;
  assign fl_oe_n    = q.oe_n;
  assign fl_we_n    = q.we_n;
  assign fl_dq_out  = q.dq;
  assign fl_dq_oe_n = q.dq_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_start_addr;
    @(posedge mclk) disable iff (reset) $rose(busy) |-> fl_addr == $past(poll_addr);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("poll address not taken");
  property p_addr_hold;
    @(posedge mclk) disable iff (reset) busy && $past(busy) |-> $stable(fl_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("poll address moved");
  property p_data_after;
    @(posedge mclk) disable iff (reset) done && !failed |-> $past(q.ph) == PH_E;
  endproperty
  a_data_after: assert property (p_data_after) else $error("data not from next read");
  property p_read_width;
    @(posedge mclk) disable iff (reset) $fell(fl_oe_n) |-> (!fl_oe_n && fl_dq_oe_n)[*7] ##1 fl_oe_n;
  endproperty
  a_read_width: assert property (p_read_width) else $error("bad read strobe");
  property p_two_reads;
    @(posedge mclk) disable iff (reset) done && !q.dp |-> q.rds >= 3'd3;
  endproperty
  a_two_reads: assert property (p_two_reads) else $error("toggle done too early");
  property p_reset_after_recheck;
    @(posedge mclk) disable iff (reset)
      $fell(fl_we_n) |-> $past(q.ph) == PH_D || ($past(q.dp) && $past(q.ph) == PH_C);
  endproperty
  a_reset_after_recheck: assert property (p_reset_after_recheck) else $error("no recheck");
  property p_restart;
    @(posedge mclk) disable iff (reset) q.st == S_HOLD && !pause |=> q.st == S_RD && q.ph == PH_A;
  endproperty
  a_restart: assert property (p_restart) else $error("resume not at first read");
  property p_reset_cmd;
    @(posedge mclk) disable iff (reset)
      $fell(fl_we_n) |-> (fl_dq_out == CMD_RESET && !fl_dq_oe_n)[*4] ##1 fl_we_n ##3 failed;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command wrong");
endmodule // flpoll_ctrl
`default_nettype wire

/* File: verif/flpoll_dev.sv */
// flash device model answering status reads
`timescale 1ns/1ns
`default_nettype none
module flpoll_dev
  import flpoll_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [1:0] op,
  input  wire logic [7:0] datum,
  input  wire logic [3:0] nbusy,
  input  wire logic       fail,
  input  wire logic       fl_oe_n,
  input  wire logic       fl_we_n,
  input  wire logic [7:0] fl_dq_out,
  input  wire logic       fl_dq_oe_n,
  output logic [7:0]      dq,
  output logic            ready_busy_n_pin,
  output logic            got_f0
);
  logic [1:0] mode_q = 2'h0;
  logic [7:0] dat_q  = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q  = 4'h0;
  logic [3:0] nb_q   = 4'h0;
  logic       fail_q = 1'b0;
  logic       tog_q  = 1'b0;
  logic       oe_q   = 1'b1;
  logic       act;
  logic [7:0] stat;
  // ----
  // status answer
  // ----
  assign act  = (mode_q != 2'h0) && ((cnt_q < nb_q) || fail_q);
  assign stat = {(mode_q == 2'h1) & ~dat_q[7], tog_q, fail_q, 2'h1,
                 (mode_q == 2'h2) & tog_q, 2'h2};
  assign ready_busy_n_pin = ~act;
  assign dq = fl_oe_n ? ~last_q : act ? stat :
              (mode_q != 2'h0 && cnt_q == nb_q) ? {dat_q[7], stat[6:0]} : dat_q;
  always_ff @(posedge mclk)
  begin
    oe_q <= fl_oe_n;
    if (!fl_oe_n)
      last_q <= dq;
    if (go)
      {mode_q, dat_q, nb_q, fail_q, cnt_q, got_f0} <= {op, datum, nbusy, fail, 5'h00};
    else if (fl_oe_n && !oe_q)
    begin
      tog_q <= tog_q ^ act;
      cnt_q <= cnt_q + 4'(cnt_q <= nb_q);
    end
    if (!fl_we_n && !fl_dq_oe_n && fl_dq_out == CMD_RESET)
      {mode_q, fail_q, got_f0} <= {2'h0, 1'b0, 1'b1};
  end
endmodule // flpoll_dev
`default_nettype wire

/* File: verif/flash_write_status_reporting_tb.sv */
// testbench of the flash status poll controller
`timescale 1ns/1ns
`default_nettype none
module flash_write_status_reporting_tb;
  import flpoll_pkg::*;
  logic        mclk  = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic        dp_q  = 1'b0;
  logic        exp7  = 1'b0;
  logic        pause = 1'b0;
  logic        go    = 1'b0;
  logic        fail  = 1'b0;
  logic [1:0]  op    = 2'h0;
  logic [3:0]  nbusy = 4'h0;
  logic [7:0]  datum = 8'h00;
  logic [18:0] paddr = 19'h00000;
  logic        busy, done, failed, ce_n, oe_n, we_n, dq_oe_n, got_f0;
  logic [7:0]  rd_data, dq_out, dev_dq, dq_in;
  logic [18:0] fl_addr;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0]  exp_q[$];
  always #5 mclk = ~mclk;
  assign dq_in = dq_oe_n ? dev_dq : dq_out;
  flpoll_ctrl #(.AW(19)) DUT (.mclk(mclk), .reset(reset), .start(start),
    .use_data_poll(dp_q), .poll_addr(paddr), .expect_d7(exp7), .pause(pause),
    .busy(busy), .done(done), .failed(failed), .rd_data(rd_data), .fl_addr(fl_addr),
    .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_dq_in(dq_in),
    .fl_dq_out(dq_out), .fl_dq_oe_n(dq_oe_n));
  flpoll_dev u_dev (.mclk(mclk), .go(go), .op(op), .datum(datum), .nbusy(nbusy),
    .fail(fail), .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_dq_out(dq_out),
    .fl_dq_oe_n(dq_oe_n), .dq(dev_dq), .ready_busy_n_pin(), .got_f0(got_f0));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run(input logic dp, input logic [1:0] o, input logic f,
                     input logic [3:0] nb, input logic pz);
    logic [7:0]  d;
    logic [18:0] a;
    int          k;
    logic [7:0]  e;
    d = (o == 2'h2) ? 8'hFF : 8'($urandom);
    a = 19'($urandom);
    k = 0;
    @(posedge mclk);
    {op, datum, nbusy, fail, go} <= {o, d, nb, f, 1'b1};
    @(posedge mclk);
    {go, start, dp_q, paddr, exp7} <= {1'b0, 1'b1, dp, a, d[7]};
    repeat (3) @(posedge mclk);
    start <= 1'b0;
    exp_q.push_back(d);
    if (pz)
    begin
      repeat (20) @(posedge mclk);
      pause <= 1'b1;
      repeat (25) @(posedge mclk);
      #1 check(ce_n, 1'b1);
      check(busy, 1'b1);
      @(posedge mclk);
      pause <= 1'b0;
    end
    do
    begin
      @(posedge mclk);
      #1 k++;
    end
    while (done !== 1'b1 && k < 2000);
    check(k < 2000, 1'b1);
    check(failed, f);
    check(got_f0, f);
    check(fl_addr, a);
    e = exp_q.pop_front();
    check(busy, 1'b0);
    check(we_n & oe_n & dq_oe_n, 1'b1);
    if (!f)
      check(rd_data, e);
    @(posedge mclk);
    #1 check(done, 1'b0);
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    void'($urandom(70));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1 check(busy, 1'b0);
    check({ce_n, oe_n, we_n, dq_oe_n}, 4'hF);
    check({rd_data, dq_out}, 16'h0000);
    for (int i = 0; i < 8; i++)
      run(i[0], i[1] ? 2'h2 : 2'h1, i[2], 4'($urandom_range(0, 4)), 1'b0);
    run(1'b0, 2'h1, 1'b0, 4'hC, 1'b1);
    run(1'b1, 2'h2, 1'b0, 4'h9, 1'b1);
    stop_test();
  end
  initial
  begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule // flash_write_status_reporting_tb
`default_nettype wire
